//--- hw/lom_consts.svh
// constants for the lane operating mode selector
// What this block does
// R1: derive one of ten operating modes from emergency, two opening inputs, two switches
// R2: flaps closed while no opening is processed, except emergency and fully free
// R3: continuous opening level means free passage, pulses mean reader-controlled passage
// R4: emergency: motors off, springs open flaps, inputs and zones ignored, both inhibits
// R5: both switches off: flaps closed, inputs ignored, zones watched, both inhibits
// R6: controlled entry: entry green, pulses used, inhibit off; exit red and inhibited
// R7: controlled exit mirrors controlled entry with the sides swapped
// R8: bidirectional: both green, pulses used; an opening makes it one-sided for a while
// R9: during that one-sided phase the other side shows red, is blocked and inhibited
// R10: free entry: open when entry zone is entered; exit red, ignored, inhibited
// R11: free exit mirrors free entry with the sides swapped
// R12: entry continuous, exit pulsed, both on: free entry, controlled exit, both green
// R13: entry pulsed, exit continuous, both on: free exit, controlled entry, both green
// R14: mixed modes: once open from one side the other side turns red and blocked
// R15: fully free: flaps held open with motors on, zones ignored, both inhibits, green
// R16: fully free: one passage-counting pulse per passage
// R17: a reader-controlled side detects tailgating and unauthorised presence
// R18: a blocked side with watched zone detects unauthorised entry
// R19: tailgating drives alarm relay two and, if enabled, a rapid buzzer
// R20: entry from blocked side drives alarm relay three, slow buzzer, clears on leaving
// R21: zone occupied on a permitted side without opening for 5 s flags relay three
// R22: an opening level counts as continuous only after a set qualification time
// R23: opening inputs on a side whose switch is off are ignored
`ifndef LOM_CONSTS_SVH
`define LOM_CONSTS_SVH
`define LOM_CLK_HZ 100000000
`define LOM_MS_PER_S 1000
`define LOM_PRESENCE_S 5
`define LOM_PRESENCE_MS (`LOM_PRESENCE_S * `LOM_MS_PER_S)
`define LOM_MS_W 13
`define LOM_TICK_W 17
`define LOM_OFS_CTRL 4'h0
`define LOM_OFS_QUAL 4'h4
`define LOM_OFS_STATUS 4'h8
`define LOM_OFS_PASSCNT 4'hc
`define LOM_CTRL_BUZ_BIT 0
`define LOM_CTRL_RST 1'b1
`define LOM_QUAL_W 12
`define LOM_QUAL_RST 12'h3e8
`define LOM_BUZ_W 10
`define LOM_BUZ_FAST_BIT 6
`define LOM_BUZ_SLOW_BIT 9
`define LOM_PASS_W 16
`define LOM_SYNC_W 9
`endif

//--- hw/lom_pkg.sv
// types shared by the lane operating mode selector
package lom_pkg;
  typedef enum logic [3:0] {
    LOM_EMERG, LOM_OOS, LOM_CTRL_ENT, LOM_CTRL_EXIT, LOM_BIDIR,
    LOM_FREE_ENT, LOM_FREE_EXIT, LOM_FENT_CEXIT, LOM_FEXIT_CENT, LOM_FULL_FREE
  } lom_mode_e;
  typedef enum logic [1:0] {LOM_LN_IDLE, LOM_LN_OPEN, LOM_LN_HELD} lom_lane_e;
endpackage

//--- hw/lom_selector.sv
// lane operating mode selector: mode decode, lane sequencing, alarms, avalon registers
//
// The Avalon-MM register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "lom_consts.svh"
module lom_selector import lom_pkg::*; #(
  parameter int unsigned MS_TICK_CYCLES = `LOM_CLK_HZ / `LOM_MS_PER_S
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic emergency_input,
  input wire logic entry_open_input,
  input wire logic exit_open_input,
  input wire logic entry_direction_switch,
  input wire logic exit_direction_switch,
  input wire logic entry_zone_photocell,
  input wire logic exit_zone_photocell,
  input wire logic [1:0] safety_photocells,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic flaps_open_cmd,
  output logic motor_power_en,
  output logic entry_indicator_green,
  output logic exit_indicator_green,
  output logic entry_reader_inhibit,
  output logic exit_reader_inhibit,
  output logic alarm_relay2,
  output logic alarm_relay3,
  output logic buzzer,
  output logic pass_count_pulse
);
  // two-flop synchronisers for every lane input pin (not the avalon port); only s2 is read
  logic [`LOM_SYNC_W-1:0] s1_ff, s2_ff;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else if (ce) begin
      s1_ff <= {safety_photocells, exit_zone_photocell, entry_zone_photocell,
                exit_direction_switch, entry_direction_switch, exit_open_input,
                entry_open_input, emergency_input};
      s2_ff <= s1_ff;
    end
  end
  logic emerg_ok;
  logic [1:0] open_s, sw_s, zone_s, safe_s;
  assign emerg_ok = s2_ff[0];
  assign open_s = s2_ff[2:1];
  assign sw_s = s2_ff[4:3];
  assign zone_s = s2_ff[6:5];
  assign safe_s = s2_ff[8:7];

  // millisecond tick and free-running buzzer phase counter
  logic [`LOM_TICK_W-1:0] tick_ff, nxt_tick;
  logic [`LOM_BUZ_W-1:0] buz_ff, nxt_buz;
  logic ms_tick;
  assign ms_tick = (tick_ff == `LOM_TICK_W'(MS_TICK_CYCLES - 1));
  always_comb begin
    nxt_tick = ms_tick ? '0 : tick_ff + 1'b1;
    nxt_buz = ms_tick ? buz_ff + 1'b1 : buz_ff;
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tick_ff <= '0;
      buz_ff <= '0;
    end else if (ce) begin
      tick_ff <= nxt_tick;
      buz_ff <= nxt_buz;
    end
  end

  // register state, declared early since qualification and buzzer read it
  logic buz_en_ff, nxt_buz_en;
  logic [`LOM_QUAL_W-1:0] qual_ff, nxt_qual;
  logic [`LOM_PASS_W-1:0] pcnt_ff, nxt_pcnt;
  lom_mode_e mode_ff, nxt_mode;
  lom_lane_e lane_ff, nxt_lane;
  logic owner_ff, nxt_owner;
  logic [1:0] allow, blocked, ctrl_side, free_side, req;
  logic active;

  // per side: pulse/continuous classification and unattended-presence timer
  logic prev_ff [2];
  logic cont_ff [2];
  logic [`LOM_QUAL_W-1:0] qcnt_ff [2];
  logic [`LOM_MS_W-1:0] pres_cnt_ff [2];
  logic pres_ff [2];
  logic ue_ff [2];
  logic [1:0] pulse, pres_v, ue_v;
  for (genvar s = 0; s < 2; s++) begin : g_side
    logic nxt_prev, nxt_cont, nxt_pres, nxt_ue;
    logic [`LOM_QUAL_W-1:0] nxt_qcnt;
    logic [`LOM_MS_W-1:0] nxt_pcnt_s;
    logic watch;
    // a level shorter than the qualification time is a pulse on its fall
    assign pulse[s] = prev_ff[s] & ~open_s[s] & ~cont_ff[s]; // R3 R22
    assign pres_v[s] = pres_ff[s];
    assign ue_v[s] = ue_ff[s];
    // presence is only timed on an idle controlled side with someone in its zone
    assign watch = ctrl_side[s] & (lane_ff == LOM_LN_IDLE) & zone_s[s];
    always_comb begin
      nxt_prev = open_s[s];
      nxt_qcnt = '0;
      if (open_s[s]) begin
        nxt_qcnt = (ms_tick && qcnt_ff[s] != '1) ? qcnt_ff[s] + 1'b1 : qcnt_ff[s];
      end
      nxt_cont = open_s[s] & (cont_ff[s] | (qcnt_ff[s] >= qual_ff)); // R22
      nxt_pcnt_s = '0;
      if (watch && !pulse[s]) begin
        nxt_pcnt_s = (ms_tick && pres_cnt_ff[s] != '1) ? pres_cnt_ff[s] + 1'b1
                                                       : pres_cnt_ff[s];
      end
      // set wins over clear: clearing only while the zone is empty or a pulse came
      nxt_pres = pres_ff[s];
      if (!zone_s[s] || pulse[s]) begin
        nxt_pres = 1'b0;
      end
      if (watch && !pulse[s] && pres_cnt_ff[s] >= `LOM_MS_W'(`LOM_PRESENCE_MS)) begin
        nxt_pres = 1'b1; // R17 R21
      end
      nxt_ue = ue_ff[s];
      if (!zone_s[s]) begin
        nxt_ue = 1'b0; // R20
      end
      if (blocked[s] && zone_s[s]) begin
        nxt_ue = 1'b1; // R18 R20
      end
    end
    always_ff @(posedge clock) begin
      if (!rst_b) begin
        prev_ff[s] <= 1'b0;
        cont_ff[s] <= 1'b0;
        qcnt_ff[s] <= '0;
        pres_cnt_ff[s] <= '0;
        pres_ff[s] <= 1'b0;
        ue_ff[s] <= 1'b0;
      end else if (ce) begin
        prev_ff[s] <= nxt_prev;
        cont_ff[s] <= nxt_cont;
        qcnt_ff[s] <= nxt_qcnt;
        pres_cnt_ff[s] <= nxt_pcnt_s;
        pres_ff[s] <= nxt_pres;
        ue_ff[s] <= nxt_ue;
      end
    end
  end

  // mode decode; a switch that is off hides its opening input entirely
  logic [1:0] cont_v;
  assign cont_v = {cont_ff[1] & sw_s[1], cont_ff[0] & sw_s[0]}; // R23
  always_comb begin
    nxt_mode = LOM_OOS;
    if (!emerg_ok) begin
      nxt_mode = LOM_EMERG; // R1 R4
    end else begin
      case (sw_s)
        2'b00: nxt_mode = LOM_OOS; // R5
        2'b01: nxt_mode = cont_v[0] ? LOM_FREE_ENT : LOM_CTRL_ENT; // R6 R10
        2'b10: nxt_mode = cont_v[1] ? LOM_FREE_EXIT : LOM_CTRL_EXIT; // R7 R11
        2'b11: begin
          case (cont_v)
            2'b00: nxt_mode = LOM_BIDIR; // R8
            2'b01: nxt_mode = LOM_FENT_CEXIT; // R12
            2'b10: nxt_mode = LOM_FEXIT_CENT; // R13
            default: nxt_mode = LOM_FULL_FREE; // R15
          endcase
        end
        default: nxt_mode = LOM_OOS;
      endcase
    end
  end

  // side roles follow the registered mode only; reading the live switches here would let
  // indicators and mode disagree for a cycle whenever a switch moves
  assign active = (mode_ff != LOM_EMERG) && (mode_ff != LOM_OOS) && (mode_ff != LOM_FULL_FREE);
  always_comb begin
    case (mode_ff)
      LOM_CTRL_ENT: {allow, free_side} = 4'b0100; // R6
      LOM_CTRL_EXIT: {allow, free_side} = 4'b1000; // R7
      LOM_BIDIR: {allow, free_side} = 4'b1100; // R8
      LOM_FREE_ENT: {allow, free_side} = 4'b0101; // R10
      LOM_FREE_EXIT: {allow, free_side} = 4'b1010; // R11
      LOM_FENT_CEXIT: {allow, free_side} = 4'b1101; // R12
      LOM_FEXIT_CENT: {allow, free_side} = 4'b1110; // R13
      default: {allow, free_side} = 4'b0000;
    endcase
    ctrl_side = allow & ~free_side; // R3
    for (int s = 0; s < 2; s++) begin
      // the far side of an opened lane is blocked until it closes
      blocked[s] = (mode_ff == LOM_OOS) | (active & (~allow[s]
                   | ((lane_ff == LOM_LN_OPEN) & (owner_ff != 1'(s))))); // R9 R14
      req[s] = (ctrl_side[s] & pulse[s]) | (free_side[s] & zone_s[s]); // R6 R10
    end
  end

  // passage: both safety cells interrupted, then both clear
  logic pass_arm_ff, nxt_pass_arm, pass_evt;
  assign pass_evt = pass_arm_ff & (safe_s == 2'b00);
  always_comb begin
    nxt_pass_arm = pass_arm_ff;
    if (safe_s == 2'b11) begin
      nxt_pass_arm = 1'b1;
    end else if (pass_evt) begin
      nxt_pass_arm = 1'b0;
    end
  end

  // lane sequencer; further requests while open are ignored (no storage)
  always_comb begin
    nxt_lane = lane_ff;
    nxt_owner = owner_ff;
    case (lane_ff)
      LOM_LN_IDLE: begin
        if (mode_ff == LOM_EMERG || mode_ff == LOM_FULL_FREE) begin
          nxt_lane = LOM_LN_HELD; // R4 R15
        end else if (req[0]) begin
          nxt_lane = LOM_LN_OPEN;
          nxt_owner = 1'b0;
        end else if (req[1]) begin
          nxt_lane = LOM_LN_OPEN; // R8
          nxt_owner = 1'b1;
        end
      end
      LOM_LN_OPEN: begin
        if (mode_ff == LOM_EMERG || mode_ff == LOM_FULL_FREE) begin
          nxt_lane = LOM_LN_HELD;
        end else if (!allow[owner_ff] || pass_evt || ue_v[~owner_ff]) begin
          nxt_lane = LOM_LN_IDLE; // R2
        end
      end
      LOM_LN_HELD: begin
        if (mode_ff != LOM_EMERG && mode_ff != LOM_FULL_FREE) begin
          nxt_lane = LOM_LN_IDLE;
        end
      end
      default: nxt_lane = LOM_LN_IDLE;
    endcase
  end

  // tailgating: the owner's zone empties and is entered again while still open
  logic tg_clr_ff, nxt_tg_clr, tg_ff, nxt_tg;
  logic own_ctrl;
  assign own_ctrl = (lane_ff == LOM_LN_OPEN) & ctrl_side[owner_ff];
  always_comb begin
    nxt_tg_clr = own_ctrl & (tg_clr_ff | ~zone_s[owner_ff]);
    nxt_tg = tg_ff;
    if (lane_ff == LOM_LN_IDLE && zone_s == 2'b00) begin
      nxt_tg = 1'b0;
    end
    if (own_ctrl && tg_clr_ff && zone_s[owner_ff]) begin
      nxt_tg = 1'b1; // R17 R19
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      mode_ff <= LOM_EMERG;
      lane_ff <= LOM_LN_IDLE;
      owner_ff <= 1'b0;
      pass_arm_ff <= 1'b0;
      tg_clr_ff <= 1'b0;
      tg_ff <= 1'b0;
    end else if (ce) begin
      mode_ff <= nxt_mode;
      lane_ff <= nxt_lane;
      owner_ff <= nxt_owner;
      pass_arm_ff <= nxt_pass_arm;
      tg_clr_ff <= nxt_tg_clr;
      tg_ff <= nxt_tg;
    end
  end

  // registered outputs
  logic flaps_ff, motor_ff, pass_p_ff, r2_ff, r3_ff, buzz_ff;
  logic [1:0] green_ff, inh_ff;
  logic nxt_flaps, nxt_motor, nxt_pass_p, nxt_r2, nxt_r3, nxt_buzz;
  logic [1:0] nxt_green, nxt_inh;
  always_comb begin
    nxt_motor = (mode_ff != LOM_EMERG); // R4
    nxt_flaps = (lane_ff != LOM_LN_IDLE); // R2 R15
    nxt_pass_p = (mode_ff == LOM_FULL_FREE) & pass_evt; // R16
    nxt_r2 = tg_ff; // R19
    nxt_r3 = (|ue_v) | (|pres_v); // R20 R21
    // rapid tone wins over slow tone when both alarms stand
    nxt_buzz = buz_en_ff & (nxt_r2 ? buz_ff[`LOM_BUZ_FAST_BIT]
                                   : (nxt_r3 & buz_ff[`LOM_BUZ_SLOW_BIT])); // R19 R20
    case (mode_ff)
      LOM_EMERG: begin
        nxt_green = 2'b11;
        nxt_inh = 2'b11; // R4
      end
      LOM_OOS: begin
        nxt_green = 2'b00;
        nxt_inh = 2'b11; // R5
      end
      LOM_FULL_FREE: begin
        nxt_green = 2'b11;
        nxt_inh = 2'b11; // R15
      end
      default: begin
        nxt_green = ~blocked; // R6 R7 R9 R14
        nxt_inh = blocked; // R6 R7 R9
      end
    endcase
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      flaps_ff <= 1'b0;
      motor_ff <= 1'b0;
      pass_p_ff <= 1'b0;
      r2_ff <= 1'b0;
      r3_ff <= 1'b0;
      buzz_ff <= 1'b0;
      green_ff <= 2'b00;
      inh_ff <= 2'b11;
    end else if (ce) begin
      flaps_ff <= nxt_flaps;
      motor_ff <= nxt_motor;
      pass_p_ff <= nxt_pass_p;
      r2_ff <= nxt_r2;
      r3_ff <= nxt_r3;
      buzz_ff <= nxt_buzz;
      green_ff <= nxt_green;
      inh_ff <= nxt_inh;
    end
  end
  assign flaps_open_cmd = flaps_ff;
  assign motor_power_en = motor_ff;
  assign pass_count_pulse = pass_p_ff;
  assign alarm_relay2 = r2_ff;
  assign alarm_relay3 = r3_ff;
  assign buzzer = buzz_ff;
  assign entry_indicator_green = green_ff[0];
  assign exit_indicator_green = green_ff[1];
  assign entry_reader_inhibit = inh_ff[0];
  assign exit_reader_inhibit = inh_ff[1];

  // avalon slave: one wait state, readdata latched on the first edge
  logic ack_ff, nxt_ack, req_bus, wr_go;
  logic [31:0] rd_ff, nxt_rd, wmerge;
  assign req_bus = avs_read | avs_write;
  assign avs_waitrequest = req_bus & ~(ack_ff & ce);
  assign wr_go = avs_write & ack_ff;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmerge[b*8 +: 8] = avs_byteenable[b] ? avs_writedata[b*8 +: 8] : 8'h00;
    end
  end
  always_comb begin
    nxt_ack = req_bus & ~ack_ff;
    nxt_rd = rd_ff;
    nxt_buz_en = buz_en_ff;
    nxt_qual = qual_ff;
    nxt_pcnt = pass_evt ? pcnt_ff + 1'b1 : pcnt_ff;
    if (avs_read && !ack_ff) begin
      case (avs_address)
        `LOM_OFS_CTRL: nxt_rd = {31'h0, buz_en_ff};
        `LOM_OFS_QUAL: nxt_rd = {20'h0, qual_ff};
        `LOM_OFS_STATUS: nxt_rd = {18'h0, cont_v, motor_ff, flaps_ff, r3_ff, r2_ff,
                                   inh_ff, green_ff, mode_ff};
        `LOM_OFS_PASSCNT: nxt_rd = {16'h0, pcnt_ff};
        default: nxt_rd = 32'h0;
      endcase
    end
    if (wr_go && avs_address == `LOM_OFS_CTRL && avs_byteenable[0]) begin
      nxt_buz_en = wmerge[`LOM_CTRL_BUZ_BIT];
    end
    if (wr_go && avs_address == `LOM_OFS_QUAL) begin
      nxt_qual = {avs_byteenable[1] ? wmerge[11:8] : qual_ff[11:8],
                  avs_byteenable[0] ? wmerge[7:0] : qual_ff[7:0]};
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ack_ff <= 1'b0;
      rd_ff <= 32'h0;
      buz_en_ff <= `LOM_CTRL_RST;
      qual_ff <= `LOM_QUAL_RST;
      pcnt_ff <= '0;
    end else if (ce) begin
      ack_ff <= nxt_ack;
      rd_ff <= nxt_rd;
      buz_en_ff <= nxt_buz_en;
      qual_ff <= nxt_qual;
      pcnt_ff <= nxt_pcnt;
    end
  end
  assign avs_readdata = rd_ff;

  // checks on the decoded behaviour
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_decode;
    ce && !emerg_ok |=> mode_ff == LOM_EMERG;
  endproperty
  a_decode: assert property (p_decode) else $error("emergency not decoded"); // R1
  property p_closed;
    ce && lane_ff == LOM_LN_IDLE && active && nxt_lane == LOM_LN_IDLE |=> !flaps_open_cmd;
  endproperty
  a_closed: assert property (p_closed) else $error("flaps open while idle"); // R2
  property p_emerg;
    ce && mode_ff == LOM_EMERG |=> !motor_power_en && entry_reader_inhibit && exit_reader_inhibit;
  endproperty
  a_emerg: assert property (p_emerg) else $error("emergency outputs wrong"); // R4
  property p_oos;
    ce && mode_ff == LOM_OOS |=> !entry_indicator_green && !exit_indicator_green
      && entry_reader_inhibit && exit_reader_inhibit;
  endproperty
  a_oos: assert property (p_oos) else $error("out of service outputs wrong"); // R5
  property p_ctrl_ent;
    ce && mode_ff == LOM_CTRL_ENT |=> entry_indicator_green && !entry_reader_inhibit
      && !exit_indicator_green && exit_reader_inhibit;
  endproperty
  a_ctrl_ent: assert property (p_ctrl_ent) else $error("controlled entry sides wrong"); // R6
  property p_one_side;
    ce && mode_ff == LOM_BIDIR && lane_ff == LOM_LN_OPEN && !owner_ff
      |=> !exit_indicator_green && exit_reader_inhibit;
  endproperty
  a_one_side: assert property (p_one_side) else $error("far side not blocked"); // R9
  property p_full;
    ce && mode_ff == LOM_FULL_FREE ##1 ce && mode_ff == LOM_FULL_FREE |=> flaps_open_cmd
      && motor_power_en && entry_indicator_green && exit_indicator_green;
  endproperty
  a_full: assert property (p_full) else $error("fully free outputs wrong"); // R15
  property p_count;
    ce && mode_ff == LOM_FULL_FREE && pass_evt |=> pass_count_pulse ##1 !pass_count_pulse;
  endproperty
  a_count: assert property (p_count) else $error("passage pulse wrong"); // R16
  property p_tail;
    ce && own_ctrl && tg_clr_ff && zone_s[owner_ff] ##1 ce |=> alarm_relay2;
  endproperty
  a_tail: assert property (p_tail) else $error("tailgating not flagged"); // R19
  property p_qual;
    ce && !open_s[0] |=> !cont_ff[0];
  endproperty
  a_qual: assert property (p_qual) else $error("continuous held without level"); // R22
endmodule // lom_selector
`default_nettype wire

//--- test/lom_partner.sv
// model of the card reader and the lane photocells beside the selector
`timescale 1ns/1ps
`default_nettype none
module lom_partner (
  input wire logic clock,
  input wire logic entry_reader_inhibit,
  input wire logic exit_reader_inhibit,
  output logic entry_open_input,
  output logic exit_open_input,
  output logic entry_zone_photocell,
  output logic exit_zone_photocell,
  output logic [1:0] safety_photocells
);
  // idle: no card, no beam interrupted
  initial begin
    entry_open_input = 1'b0;
    exit_open_input = 1'b0;
    entry_zone_photocell = 1'b0;
    exit_zone_photocell = 1'b0;
    safety_photocells = 2'b00;
  end

  // a card read gives a short pulse; an inhibited reader refuses the card
  task automatic card(input logic side);
    if (side ? exit_reader_inhibit : entry_reader_inhibit) return;
    if (side) exit_open_input <= 1'b1;
    else entry_open_input <= 1'b1;
    repeat (3) @(posedge clock);
    if (side) exit_open_input <= 1'b0;
    else entry_open_input <= 1'b0;
  endtask

  // a steady level stands for free passage on that side
  task automatic hold(input logic side, input logic v);
    if (side) exit_open_input <= v;
    else entry_open_input <= v;
  endtask

  task automatic zone(input logic side, input logic v);
    if (side) exit_zone_photocell <= v;
    else entry_zone_photocell <= v;
    @(posedge clock);
  endtask

  // a person crosses: both safety beams cut together, then both clear
  task automatic pass();
    safety_photocells <= 2'b11;
    repeat (4) @(posedge clock);
    safety_photocells <= 2'b00;
    repeat (2) @(posedge clock);
  endtask
endmodule // lom_partner
`default_nettype wire

//--- test/testbench.sv
// self-checking bench for the lane operating mode selector
`timescale 1ns/1ps
`default_nettype none
`include "lom_consts.svh"
module testbench;
  logic clock, rst_b, ce, emergency_input, entry_direction_switch, exit_direction_switch;
  logic [3:0] avs_address, avs_byteenable;
  logic avs_read, avs_write;
  logic [31:0] avs_writedata;
  wire logic [31:0] avs_readdata;
  wire logic avs_waitrequest, flaps_open_cmd, motor_power_en, buzzer, pass_count_pulse;
  wire logic entry_indicator_green, exit_indicator_green, alarm_relay2, alarm_relay3;
  wire logic entry_reader_inhibit, exit_reader_inhibit, ent_in, ex_in, zn_e, zn_x;
  wire logic [1:0] safety;
  wire logic [5:0] outs = {flaps_open_cmd, motor_power_en, entry_indicator_green,
    exit_indicator_green, entry_reader_inhibit, exit_reader_inhibit};
  int fails = 0;
  int n_tests = 0;
  int npulse = 0;

  lom_selector #(.MS_TICK_CYCLES(4)) i_dut (.clock(clock), .rst_b(rst_b), .ce(ce),
    .emergency_input(emergency_input), .entry_open_input(ent_in), .exit_open_input(ex_in),
    .entry_direction_switch(entry_direction_switch),
    .exit_direction_switch(exit_direction_switch), .entry_zone_photocell(zn_e),
    .exit_zone_photocell(zn_x), .safety_photocells(safety), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .flaps_open_cmd(flaps_open_cmd),
    .motor_power_en(motor_power_en), .entry_indicator_green(entry_indicator_green),
    .exit_indicator_green(exit_indicator_green), .entry_reader_inhibit(entry_reader_inhibit),
    .exit_reader_inhibit(exit_reader_inhibit), .alarm_relay2(alarm_relay2),
    .alarm_relay3(alarm_relay3), .buzzer(buzzer), .pass_count_pulse(pass_count_pulse));

  lom_partner i_part (.clock(clock), .entry_reader_inhibit(entry_reader_inhibit),
    .exit_reader_inhibit(exit_reader_inhibit), .entry_open_input(ent_in),
    .exit_open_input(ex_in), .entry_zone_photocell(zn_e), .exit_zone_photocell(zn_x),
    .safety_photocells(safety));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // passage pulses are counted on the fly, since each lasts one cycle only
  always @(posedge clock) if (pass_count_pulse === 1'b1) npulse <= npulse + 1;

  task close_out;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  function logic pick(input int k);
    case (k)
      0: pick = flaps_open_cmd;
      1: pick = alarm_relay3;
      2: pick = buzzer;
      default: pick = alarm_relay2;
    endcase
  endfunction

  // bounded wait for an output level; running out shows up as a mismatch
  task wt(input int k, input logic v, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (pick(k) !== v && n < lim);
    chk(pick(k), v, "output level");
    // back on the rising edge, where the partner and the bus drive
    @(posedge clock);
  endtask

  // one avalon transfer; request held until waitrequest is seen low at a rising edge
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // one idle edge so a following call never re-raises the strobe in this time step
    @(posedge clock);
    if (n >= 50) chk(1'b0, 1'b1, "bus timeout");
  endtask

  task t_regs;
    logic [31:0] q;
    bus(0, `LOM_OFS_CTRL, 0, q);
    chk(q, 32'h1, "ctrl reset");
    bus(0, `LOM_OFS_QUAL, 0, q);
    chk(q, 32'h3e8, "qual reset");
    bus(1, `LOM_OFS_STATUS, 32'hffffffff, q);
    bus(0, `LOM_OFS_STATUS, 0, q);
    chk(q[3:0], 4'h1, "status read only");
    bus(0, 4'h2, 0, q);
    chk(q, 32'h0, "unmapped");
    // short qualification keeps the continuous cases quick
    bus(1, `LOM_OFS_QUAL, 32'h2, q);
    bus(0, `LOM_OFS_QUAL, 0, q);
    chk(q, 32'h2, "qual write");
  endtask

  // set the pins of one mode, let it settle, compare mode and idle outputs
  task mrow(input logic e, a, b, se, sx, input logic [3:0] md, input logic [5:0] ex);
    logic [31:0] q;
    emergency_input <= e;
    entry_direction_switch <= se;
    exit_direction_switch <= sx;
    i_part.hold(0, a);
    i_part.hold(1, b);
    repeat (60) @(posedge clock);
    bus(0, `LOM_OFS_STATUS, 0, q);
    chk(q[3:0], md, "mode");
    // in emergency the flaps are commanded open as well, with the motors unpowered
    chk(outs, ex, "idle outputs");
  endtask

  task t_modes;
    mrow(0, 1, 1, 1, 1, 4'h0, 6'b101111);
    mrow(1, 1, 1, 0, 0, 4'h1, 6'b010011);
    mrow(1, 0, 0, 1, 0, 4'h2, 6'b011001);
    mrow(1, 0, 0, 0, 1, 4'h3, 6'b010110);
    mrow(1, 1, 0, 0, 1, 4'h3, 6'b010110);
    mrow(1, 0, 0, 1, 1, 4'h4, 6'b011100);
    mrow(1, 1, 0, 1, 0, 4'h5, 6'b011001);
    mrow(1, 0, 1, 0, 1, 4'h6, 6'b010110);
    mrow(1, 1, 0, 1, 1, 4'h7, 6'b011100);
    mrow(1, 0, 1, 1, 1, 4'h8, 6'b011100);
    mrow(1, 1, 1, 1, 1, 4'h9, 6'b111111);
  endtask

  task t_ctrl;
    logic [31:0] c0, c1;
    mrow(1, 0, 0, 1, 0, 4'h2, 6'b011001);
    bus(0, `LOM_OFS_PASSCNT, 0, c0);
    i_part.card(0);
    wt(0, 1, 60);
    chk({exit_indicator_green, exit_reader_inhibit}, 2'b01, "far side blocked");
    i_part.pass();
    wt(0, 0, 60);
    bus(0, `LOM_OFS_PASSCNT, 0, c1);
    chk(c1[15:0], c0[15:0] + 16'h1, "passage count");
  endtask

  task t_bidir;
    mrow(1, 0, 0, 1, 1, 4'h4, 6'b011100);
    i_part.card(1);
    wt(0, 1, 60);
    chk({entry_indicator_green, entry_reader_inhibit}, 2'b01, "other side blocked");
    i_part.pass();
    wt(0, 0, 60);
    chk(outs, 6'b011100, "back to both green");
  endtask

  task t_free;
    mrow(1, 1, 0, 1, 0, 4'h5, 6'b011001);
    i_part.zone(0, 1);
    wt(0, 1, 60);
    i_part.zone(0, 0);
    i_part.pass();
    wt(0, 0, 60);
    i_part.zone(1, 1);
    wt(1, 1, 60);
    i_part.zone(1, 0);
    wt(1, 0, 60);
  endtask

  task t_mixed;
    mrow(1, 1, 0, 1, 1, 4'h7, 6'b011100);
    i_part.zone(0, 1);
    wt(0, 1, 60);
    chk(exit_indicator_green, 1'b0, "far side red");
    i_part.zone(0, 0);
    i_part.pass();
    wt(0, 0, 60);
  endtask

  task t_full;
    int n0;
    mrow(1, 1, 1, 1, 1, 4'h9, 6'b111111);
    n0 = npulse;
    i_part.pass();
    repeat (10) @(posedge clock);
    chk(npulse - n0, 1, "one count pulse");
    chk(outs, 6'b111111, "still open");
  endtask

  // presence alarm needs 5000 ms ticks of 4 cycles each
  task t_presence;
    mrow(1, 0, 0, 1, 0, 4'h2, 6'b011001);
    i_part.zone(0, 1);
    wt(1, 1, 21000);
    wt(2, 1, 2100);
    i_part.card(0);
    wt(1, 0, 60);
    // zone empties and is entered again while the lane is still open
    i_part.zone(0, 0);
    i_part.zone(0, 1);
    wt(3, 1, 60);
    i_part.zone(0, 0);
    i_part.pass();
    wt(0, 0, 60);
    wt(3, 0, 60);
  endtask

  initial begin
    #1000000;
    chk(1'b0, 1'b1, "watchdog");
    close_out;
  end

  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    emergency_input = 1'b1;
    entry_direction_switch = 1'b0;
    exit_direction_switch = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (11) @(posedge clock);
    chk(outs, 6'b000011, "reset outputs");
    @(posedge clock);
    rst_b <= 1'b1;
    t_regs;
    t_modes;
    t_ctrl;
    t_bidir;
    t_free;
    t_mixed;
    t_full;
    t_presence;
    close_out;
  end
endmodule // testbench
`default_nettype wire
